// *** common/acss_pkg.sv ***
/*
  constants, types and state layout of the automatic clock source selector.
  assumes a 40 MHz pclk and four frame-rate reference pins from the digital receivers.
*/
package acss_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int LOSS_TIME_NS = 62500;
  localparam int LOSS_CYC = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERIOD_TOL_CYC = 8;

  // ----------------------------------------
  // inputs
  // ----------------------------------------
  localparam int NUM_IN = 4;
  localparam int CNT_W = 12;
  localparam int IN_WORD = 0;
  localparam int IN_OPTICAL = 1;
  localparam int IN_COAX = 2;
  localparam int IN_TIMECODE = 3;

  // ----------------------------------------
  // rate codes and nominal periods in pclk cycles
  // ----------------------------------------
  typedef logic [3:0] acss_rate_t;
  localparam acss_rate_t RATE_NONE = 4'h0;
  localparam acss_rate_t RATE_48K = 4'h3;
  localparam acss_rate_t RATE_DOUBLE_MIN = 4'h4;
  localparam acss_rate_t RATE_QUAD_MIN = 4'h7;
  localparam acss_rate_t RATE_MAX = 4'h9;
  localparam logic [9:0][11:0] RATE_PERIOD = {12'h0d0, 12'h0e3, 12'h138, 12'h1a0, 12'h1c5,
                                              12'h271, 12'h341, 12'h38b, 12'h4e2, 12'h000};
  localparam logic [3:0] OPT_CH_SINGLE = 4'h8;
  localparam logic [3:0] OPT_CH_DOUBLE = 4'h4;
  localparam logic [3:0] OPT_CH_QUAD = 4'h2;

  // ----------------------------------------
  // input states
  // ----------------------------------------
  localparam logic [1:0] IN_ST_NOLOCK = 2'h0;
  localparam logic [1:0] IN_ST_LOCK = 2'h1;
  localparam logic [1:0] IN_ST_SYNC = 2'h2;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_PREF_LSB = 1;
  localparam int CTRL_RATE_LSB = 4;
  localparam int CTRL_DMON_BIT = 8;
  localparam int CTRL_REC_BIT = 9;
  localparam logic [9:0] CTRL_RST = 10'h031;
  localparam int ST_REF_LSB = 8;
  localparam int ST_RATE_LSB = 16;
  localparam int ST_CH_LSB = 20;
  localparam int ST_ERR_BIT = 24;
  localparam int IRQ_RATE_ERR = 0;
  localparam int IRQ_REF_CHG = 1;
  localparam int IRQ_FALLBACK = 2;

  // ----------------------------------------
  // clock reference, one-hot
  // ----------------------------------------
  typedef enum logic [4:0] {
    REF_INT = 5'b00001,
    REF_WORD = 5'b00010,
    REF_OPTICAL = 5'b00100,
    REF_COAX = 5'b01000,
    REF_TIMECODE = 5'b10000
  } acss_ref_e;

  typedef struct packed {
    acss_ref_e clock_sel;
    acss_rate_t op_rate;
    logic [3:0] opt_channels;
    logic two_way_sample_multiplex;
    logic four_way_sample_multiplex;
  } acss_link_s;

  typedef struct packed {
    logic [NUM_IN-1:0] s1;
    logic [NUM_IN-1:0] s2;
    logic [NUM_IN-1:0] pv;
    logic [NUM_IN-1:0][CNT_W-1:0] cnt;
    logic [NUM_IN-1:0][3:0] cls;
    logic [NUM_IN-1:0] lock;
    logic [9:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic rate_err;
    logic monitor;
    acss_link_s lnk;
  } acss_state_s;

endpackage : acss_pkg

// *** src/acss_top.sv ***
/*
  automatic clock source selector: measures four digital input frame clocks, picks the clock
  reference, reports lock/sync and rate, and sits as an APB slave.
  assumes apb master on pclk; input frame clocks asynchronous to pclk.
*/
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps

module acss_top import acss_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frame clocks from word, optical, coaxial, timecode receivers
  input wire logic [NUM_IN-1:0] input_frame_clk,
  // clocking and routing results
  output acss_link_s link_status,
  output logic rate_error,
  output logic host_driven_direct_monitor,
  output logic irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic acss_rate_t classify(input logic [CNT_W-1:0] per);
    acss_rate_t r;
    r = RATE_NONE;
    for (int k = 1; k <= 9; k++) begin
      if ((per + 12'(PERIOD_TOL_CYC) >= RATE_PERIOD[k]) && (per <= RATE_PERIOD[k] + 12'(PERIOD_TOL_CYC))) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction : classify

  function automatic acss_ref_e ref_of(input int i);
    acss_ref_e r;
    case (i)
      IN_WORD: r = REF_WORD;
      IN_OPTICAL: r = REF_OPTICAL;
      IN_COAX: r = REF_COAX;
      IN_TIMECODE: r = REF_TIMECODE;
      default: r = REF_INT;
    endcase
    return r;
  endfunction : ref_of

  acss_state_s q;
  acss_state_s d;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [CNT_W-1:0] per;
    logic auto_mode;
    logic [1:0] pref;
    acss_rate_t host_rate;
    acss_ref_e nref;
    logic cur_ok;
    logic found;
    acss_rate_t ref_rate;
    logic ref_locked;
    logic [2:0] ev;
    logic [31:0] rd;
    logic [1:0] ist;
    logic hit;
    logic wr;
    per = '0;
    auto_mode = q.ctrl[CTRL_AUTO_BIT];
    pref = q.ctrl[CTRL_PREF_LSB +: 2];
    host_rate = q.ctrl[CTRL_RATE_LSB +: 4];
    nref = REF_INT;
    cur_ok = 1'b0;
    found = 1'b0;
    ref_rate = RATE_NONE;
    ref_locked = 1'b0;
    ev = '0;
    rd = '0;
    ist = IN_ST_NOLOCK;
    hit = 1'b0;
    wr = 1'b0;
    d = q;

    // input synchronisers and period measurement, every input in parallel
    d.s1 = input_frame_clk;
    d.s2 = q.s1;
    d.pv = q.s2;
    for (int i = 0; i < NUM_IN; i++) begin
      if (q.s2[i] && !q.pv[i]) begin
        per = q.cnt[i] + 12'h001;
        d.cls[i] = classify(per);
        d.lock[i] = (classify(per) != RATE_NONE) && (classify(per) == q.cls[i]);
        d.cnt[i] = '0;
      end else if (q.cnt[i] >= 12'(LOSS_CYC - 1)) begin
        d.lock[i] = 1'b0;
        d.cls[i] = RATE_NONE;
      end else begin
        d.cnt[i] = q.cnt[i] + 12'h001;
      end
    end

    // clock reference choice
    for (int i = 0; i < NUM_IN; i++) begin
      if (q.lnk.clock_sel == ref_of(i) && q.lock[i]) begin
        cur_ok = 1'b1;
      end
    end
    if (!auto_mode) begin
      nref = REF_INT;
    end else if (q.lock[pref]) begin
      nref = ref_of(int'(pref));
    end else if (cur_ok) begin
      nref = q.lnk.clock_sel;
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (q.lock[i] && !found) begin
          nref = ref_of(i);
          found = 1'b1;
        end
      end
    end
    d.lnk.clock_sel = nref;

    for (int i = 0; i < NUM_IN; i++) begin
      if (nref == ref_of(i)) begin
        ref_rate = q.cls[i];
        ref_locked = q.lock[i];
      end
    end

    // operating rate and optical multiplexing
    d.lnk.op_rate = (nref == REF_INT) ? host_rate : ref_rate;
    d.lnk.two_way_sample_multiplex = 1'b0;
    d.lnk.four_way_sample_multiplex = 1'b0;
    d.lnk.opt_channels = OPT_CH_SINGLE;
    if (d.lnk.op_rate >= RATE_QUAD_MIN) begin
      d.lnk.four_way_sample_multiplex = 1'b1;
      d.lnk.opt_channels = OPT_CH_QUAD;
    end else if (d.lnk.op_rate >= RATE_DOUBLE_MIN) begin
      d.lnk.two_way_sample_multiplex = 1'b1;
      d.lnk.opt_channels = OPT_CH_DOUBLE;
    end

    d.rate_err = (nref != REF_INT) && ref_locked && (ref_rate != host_rate);
    d.monitor = q.ctrl[CTRL_DMON_BIT] && q.ctrl[CTRL_REC_BIT];

    // sticky events
    ev[IRQ_RATE_ERR] = d.rate_err && !q.rate_err;
    ev[IRQ_REF_CHG] = nref != q.lnk.clock_sel;
    ev[IRQ_FALLBACK] = (nref == REF_INT) && (q.lnk.clock_sel != REF_INT);

    // apb: answer one cycle after setup
    wr = psel && penable && pwrite && q.pready;
    d.irq_stat = q.irq_stat;
    if (wr && paddr == ADDR_CTRL) begin
      d.ctrl = pwdata[9:0];
    end
    if (wr && paddr == ADDR_IRQ_MASK) begin
      d.irq_mask = pwdata[2:0];
    end
    if (wr && paddr == ADDR_IRQ_STAT) begin
      d.irq_stat = q.irq_stat & ~pwdata[2:0];
    end
    d.irq_stat = d.irq_stat | ev;
    d.irq = |(q.irq_stat & q.irq_mask);

    for (int i = 0; i < NUM_IN; i++) begin
      if (!q.lock[i]) begin
        ist = IN_ST_NOLOCK;
      end else if (q.cls[i] == q.lnk.op_rate) begin
        ist = IN_ST_SYNC;
      end else begin
        ist = IN_ST_LOCK;
      end
      rd[2*i +: 2] = ist;
    end
    rd[ST_REF_LSB +: 5] = q.lnk.clock_sel;
    rd[ST_RATE_LSB +: 4] = (q.lnk.clock_sel == REF_INT) ? (auto_mode ? RATE_NONE : host_rate)
                                                        : q.lnk.op_rate;
    rd[ST_CH_LSB +: 4] = q.lnk.opt_channels;
    rd[ST_ERR_BIT] = q.rate_err;

    hit = 1'b1;
    case (paddr)
      ADDR_CTRL: rd = {22'h00_0000, q.ctrl};
      ADDR_STATUS: rd = rd;
      ADDR_IRQ_STAT: rd = {29'h0000_0000, q.irq_stat};
      ADDR_IRQ_MASK: rd = {29'h0000_0000, q.irq_mask};
      default: begin
        rd = '0;
        hit = 1'b0;
      end
    endcase
    d.pready = psel && !penable;
    d.pslverr = psel && !penable && !hit;
    d.prdata = (psel && !penable && !pwrite) ? rd : q.prdata;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.lnk.clock_sel <= REF_INT;
      q.lnk.op_rate <= RATE_48K;
      q.lnk.opt_channels <= OPT_CH_SINGLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign link_status = q.lnk;
  assign rate_error = q.rate_err;
  assign host_driven_direct_monitor = q.monitor;
  assign irq = q.irq;

endmodule : acss_top

// *** tb/acss_src_model.sv ***
/*
  external gear: one frame clock per input.
  assumes half period in ns, zero means silent and low.
*/
`timescale 1ns/100ps
module acss_src_model (
  // half periods
  input wire logic [3:0][15:0] half_ns,
  // frame clocks
  output logic [3:0] frame_clk
);
  for (genvar g = 0; g < 4; g++) begin : g_src
    initial begin
      frame_clk[g] = 1'b0;
      forever begin
        if (half_ns[g] == 16'h0000) begin
          frame_clk[g] = 1'b0;
          #100;
        end else begin
          #(half_ns[g]) frame_clk[g] = ~frame_clk[g];
        end
      end
    end
  end
endmodule : acss_src_model

// *** tb/acss_top_asserts.sv ***
/*
  port checks of the clock source selector.
  assumes one pclk domain; bound into acss_top.
*/
`timescale 1ns/100ps
module acss_top_asserts import acss_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // results
  input wire acss_link_s link_status,
  input wire logic rate_error,
  input wire logic host_driven_direct_monitor
);
  logic [9:0] ctrl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
      ctrl_q <= pwdata[9:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_err_unmapped: assert property (pready |-> pslverr == (paddr > ADDR_IRQ_MASK || paddr[1:0] != 2'b00))
    else $error("slave error wrong");
  chk_master_internal: assert property (!ctrl_q[CTRL_AUTO_BIT] [*4] |-> link_status.clock_sel == REF_INT)
    else $error("master not internal");
  chk_single_speed: assert property (link_status.op_rate < RATE_DOUBLE_MIN |->
    link_status.opt_channels == OPT_CH_SINGLE && !link_status.two_way_sample_multiplex) else $error("single speed");
  chk_double_mux: assert property (link_status.op_rate >= RATE_DOUBLE_MIN &&
    link_status.op_rate < RATE_QUAD_MIN |-> link_status.two_way_sample_multiplex &&
    link_status.opt_channels == OPT_CH_DOUBLE) else $error("double speed");
  chk_quad_mux: assert property (link_status.op_rate >= RATE_QUAD_MIN |->
    link_status.four_way_sample_multiplex && link_status.opt_channels == OPT_CH_QUAD) else $error("quad speed");
  chk_monitor_follow: assert property (host_driven_direct_monitor ==
    $past(ctrl_q[CTRL_DMON_BIT] && ctrl_q[CTRL_REC_BIT])) else $error("monitor wrong");
  chk_rate_err_ref: assert property ($rose(rate_error) |-> link_status.clock_sel != REF_INT)
    else $error("rate error without reference");
  cover property (link_status.clock_sel == REF_TIMECODE);
  cover property (link_status.four_way_sample_multiplex);
  cover property ($rose(rate_error));
endmodule : acss_top_asserts

bind acss_top acss_top_asserts acss_top_asserts_i (.*);

// *** tb/acss_top_tb_top.sv ***
/*
  self-checking bench of the clock source selector.
  assumes acss_src_model as the far side.
*/
`timescale 1ns/100ps
module acss_top_tb_top import acss_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] input_frame_clk;
  acss_link_s link_status;
  logic rate_error;
  logic host_driven_direct_monitor;
  logic irq;
  logic [3:0][15:0] half_ns = '0;
  logic [31:0] lfsr = 32'h0000_e2da;
  logic [31:0] rd;
  logic [31:0] e;
  logic err;
  logic [4:0] r;
  int n_errors = 0;
  int tests_run = 0;
  always #12.5 pclk = ~pclk;
  acss_top acss_top_i (.*);
  acss_src_model acss_src_model_i (.half_ns(half_ns), .frame_clk(input_frame_clk));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  function automatic logic [15:0] hp(input logic [3:0] c);
    return 16'(RATE_PERIOD[c] * 25 / 2);
  endfunction : hp
  function automatic logic [31:0] est(input logic [4:0] s, input logic [3:0] c, input logic [7:0] st, input logic x);
    return {7'h00, x, (c >= RATE_QUAD_MIN) ? OPT_CH_QUAD : (c >= RATE_DOUBLE_MIN) ? OPT_CH_DOUBLE : OPT_CH_SINGLE,
      c, 3'h0, s, st};
  endfunction : est
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, 1'b1);
    if (n >= 20) complete_run();
  endtask : apb
  task automatic wsel(input logic [4:0] s);
    int n;
    n = 0;
    while (link_status.clock_sel !== s && n < 9000) begin
      @(posedge pclk);
      n++;
    end
    chk(link_status.clock_sel, s);
    if (n >= 9000) complete_run();
    repeat (3) @(posedge pclk);
  endtask : wsel
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk(link_status, {REF_INT, RATE_48K, OPT_CH_SINGLE, 2'b00});
    apb(1'b1, {lfsr[7:4] | 4'h1, lfsr[3:2], 2'b00}, lfsr);
    chk(err, 1'b1);
    apb(1'b0, paddr, 32'h0000_0000);
    chk({rd, err}, 33'h0_0000_0001);
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk(rd, 32'(CTRL_RST));
    $display("test map done");
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0007);
    half_ns[IN_WORD] <= hp(RATE_48K);
    wsel(REF_WORD);
    half_ns[IN_OPTICAL] <= hp(4'h2);
    repeat (3000) @(posedge pclk);
    chk(link_status.clock_sel, REF_WORD);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd, est(REF_WORD, RATE_48K, 8'h06, 1'b0));
    apb(1'b0, ADDR_IRQ_STAT, 32'h0000_0000);
    chk({rd[2:0], irq}, 4'h5);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0006);
    apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0002);
    apb(1'b1, ADDR_CTRL, 32'h0000_0033);
    wsel(REF_OPTICAL);
    chk(rate_error, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd, est(REF_OPTICAL, 4'h2, 8'h09, 1'b1));
    apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0002);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0000_0000);
    chk({rd[2:0], irq}, 4'h2);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0007);
    apb(1'b1, ADDR_CTRL, 32'h0000_0023);
    repeat (2) @(posedge pclk);
    chk({rate_error, irq}, 2'b01);
    apb(1'b1, ADDR_CTRL, 32'h0000_0022);
    wsel(REF_INT);
    $display("test select done");
    apb(1'b1, ADDR_CTRL, 32'h0000_0031);
    wsel(REF_WORD);
    apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0007);
    half_ns <= '0;
    wsel(REF_INT);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd, est(REF_INT, 4'h0, 8'h00, 1'b0));
    apb(1'b0, ADDR_IRQ_STAT, 32'h0000_0000);
    chk(rd[2], 1'b1);
    $display("test fallback done");
    for (int c = 1; c <= 9; c++) begin
      lfsr = lfsr_next(lfsr);
      r = 5'(2 << lfsr[1:0]);
      apb(1'b1, ADDR_CTRL, {24'h00_0000, 4'(c), 1'b0, lfsr[1:0], 1'b1});
      half_ns[lfsr[1:0]] <= hp(4'(c));
      wsel(r);
      e = est(r, 4'(c), 8'(2 << (2 * lfsr[1:0])), 1'b0);
      chk(link_status, {r, 4'(c), e[23:20], e[23:20] == OPT_CH_DOUBLE, e[23:20] == OPT_CH_QUAD});
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk(rd, e);
      half_ns <= '0;
      wsel(REF_INT);
    end
    $display("test rates done");
    apb(1'b1, ADDR_CTRL, 32'h0000_0131);
    repeat (2) @(posedge pclk);
    chk(host_driven_direct_monitor, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0331);
    repeat (2) @(posedge pclk);
    chk(host_driven_direct_monitor, 1'b1);
    $display("test monitor done");
    complete_run();
  end
endmodule : acss_top_tb_top
